// ==== logic/dwtc_timer.sv ====
// The AXI4-Lite register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module dwtc_timer (
   input  wire logic        REF_CLK_I,            // io clock, 200 MHz
   input  wire logic        RST_I,                // sync reset, high
   input  wire logic        EXTERNAL_COUNT_PIN_I, // external count pin
   input  wire logic        CAPTURE_EVENT_I,      // capture trigger pulse
   input  wire logic [3:0]  INT_ACK_I,            // interrupt serviced pulses
   output logic             TIMER_IRQ_O,          // masked flags present
   input  wire logic [5:0]  S_AXI_AWADDR,         // write address
   input  wire logic        S_AXI_AWVALID,        // write address valid
   output logic             S_AXI_AWREADY,        // write address ready
   input  wire logic [31:0] S_AXI_WDATA,          // write data
   input  wire logic [3:0]  S_AXI_WSTRB,          // write strobes
   input  wire logic        S_AXI_WVALID,         // write data valid
   output logic             S_AXI_WREADY,         // write data ready
   output logic [1:0]       S_AXI_BRESP,          // write response
   output logic             S_AXI_BVALID,         // write response valid
   input  wire logic        S_AXI_BREADY,         // write response ready
   input  wire logic [5:0]  S_AXI_ARADDR,         // read address
   input  wire logic        S_AXI_ARVALID,        // read address valid
   output logic             S_AXI_ARREADY,        // read address ready
   output logic [31:0]      S_AXI_RDATA,          // read data
   output logic [1:0]       S_AXI_RRESP,          // read response
   output logic             S_AXI_RVALID,         // read data valid
   input  wire logic        S_AXI_RREADY          // read data ready
);
   // ********************************************************
   // declarations
   // ********************************************************
   dwtc_pkg::dwtc_ctrl_s ctrl_reg;
   logic [2:0]  clock_select_reg;
   logic        sync_hold_reg;
   logic        psr_reg;
   logic [7:0]  count_low_reg;
   logic [7:0]  count_high_reg;
   logic [7:0]  compare_a_reg;
   logic [7:0]  compare_b_reg;
   logic [3:0]  flag_reg;
   logic [3:0]  mask_reg;
   logic [5:0]  awaddr_reg;
   logic [31:0] wdata_reg;
   logic        wstrb0_reg;
   logic        aw_full_reg;
   logic        w_full_reg;
   logic        wr_do;
   logic        wr_hit;
   logic [7:0]  wr_byte;
   logic        rd_hit;
   logic [7:0]  rd_byte;
   logic        timer_tick;
   logic        wide;
   logic        clear_on_match_mode;
   logic [15:0] count_now;
   logic [15:0] top_value;
   logic [15:0] max_value;
   logic [15:0] count_next;
   logic        at_max;
   logic        at_top;
   logic        match_a;
   logic        match_b;
   logic        capture_take;
   logic        count_write;

   // ********************************************************
   // tick source
   // ********************************************************
   dwtc_tick_gen u_tick (
      .clk_i                (REF_CLK_I),
      .rst_i                (RST_I),
      .clock_select_i       (clock_select_reg),
      .prescaler_reset_i    (psr_reg),
      .external_count_pin_i (EXTERNAL_COUNT_PIN_I),
      .timer_tick_o         (timer_tick)
   );

   // ********************************************************
   // write channel: address and data taken in either order
   // ********************************************************
   assign wr_do   = aw_full_reg && w_full_reg && !S_AXI_BVALID;
   assign wr_byte = wdata_reg[7:0];

   always_ff @(posedge REF_CLK_I) begin
      if (RST_I) begin
         aw_full_reg   <= 1'b0;
         w_full_reg    <= 1'b0;
         awaddr_reg    <= '0;
         wdata_reg     <= '0;
         wstrb0_reg    <= 1'b0;
         S_AXI_AWREADY <= 1'b0;
         S_AXI_WREADY  <= 1'b0;
         S_AXI_BVALID  <= 1'b0;
         S_AXI_BRESP   <= dwtc_pkg::RESP_OKAY;
      end else begin
         S_AXI_AWREADY <= !aw_full_reg && !S_AXI_AWREADY;
         S_AXI_WREADY  <= !w_full_reg && !S_AXI_WREADY;
         if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            aw_full_reg   <= 1'b1;
            awaddr_reg    <= S_AXI_AWADDR;
            S_AXI_AWREADY <= 1'b0;
         end
         if (S_AXI_WVALID && S_AXI_WREADY) begin
            w_full_reg   <= 1'b1;
            wdata_reg    <= S_AXI_WDATA;
            wstrb0_reg   <= S_AXI_WSTRB[0];
            S_AXI_WREADY <= 1'b0;
         end
         if (wr_do) begin
            aw_full_reg  <= 1'b0;
            w_full_reg   <= 1'b0;
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP  <= wr_hit ? dwtc_pkg::RESP_OKAY : dwtc_pkg::RESP_SLVERR;
         end else if (S_AXI_BVALID && S_AXI_BREADY) begin
            S_AXI_BVALID <= 1'b0;
         end
      end
   end

   always_comb begin
      case (awaddr_reg)
         dwtc_pkg::OFS_CONTROL_A, dwtc_pkg::OFS_CLOCK_SELECT,
         dwtc_pkg::OFS_SYNC_CTRL, dwtc_pkg::OFS_COUNT_LOW,
         dwtc_pkg::OFS_COUNT_HIGH, dwtc_pkg::OFS_COMPARE_A,
         dwtc_pkg::OFS_COMPARE_B, dwtc_pkg::OFS_FLAG,
         dwtc_pkg::OFS_MASK: wr_hit = 1'b1;
         default:            wr_hit = 1'b0;
      endcase
   end

   // a register changes only when its byte lane is strobed
   function automatic logic wr_to(input logic [5:0] ofs);
      wr_to = wr_do && wstrb0_reg && (awaddr_reg == ofs);
   endfunction

   // ********************************************************
   // read channel
   // ********************************************************
   always_comb begin
      rd_hit  = 1'b1;
      rd_byte = dwtc_pkg::RST_BYTE;
      case (S_AXI_ARADDR)
         dwtc_pkg::OFS_CONTROL_A:    rd_byte = {5'h00, ctrl_reg};
         dwtc_pkg::OFS_CLOCK_SELECT: rd_byte = {5'h00, clock_select_reg};
         dwtc_pkg::OFS_SYNC_CTRL:    rd_byte = {sync_hold_reg, 6'h00, psr_reg};
         dwtc_pkg::OFS_COUNT_LOW:    rd_byte = count_low_reg;
         dwtc_pkg::OFS_COUNT_HIGH:   rd_byte = count_high_reg;
         dwtc_pkg::OFS_COMPARE_A:    rd_byte = compare_a_reg;
         dwtc_pkg::OFS_COMPARE_B:    rd_byte = compare_b_reg;
         dwtc_pkg::OFS_FLAG:         rd_byte = {4'h0, flag_reg};
         dwtc_pkg::OFS_MASK:         rd_byte = {4'h0, mask_reg};
         default:                    rd_hit  = 1'b0;
      endcase
   end

   always_ff @(posedge REF_CLK_I) begin
      if (RST_I) begin
         S_AXI_ARREADY <= 1'b0;
         S_AXI_RVALID  <= 1'b0;
         S_AXI_RDATA   <= '0;
         S_AXI_RRESP   <= dwtc_pkg::RESP_OKAY;
      end else begin
         S_AXI_ARREADY <= !S_AXI_RVALID && !S_AXI_ARREADY;
         if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID  <= 1'b1;
            S_AXI_RDATA   <= {24'h000000, rd_byte};
            S_AXI_RRESP   <= rd_hit ? dwtc_pkg::RESP_OKAY : dwtc_pkg::RESP_SLVERR;
         end else if (S_AXI_RVALID && S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
         end
      end
   end

   // ********************************************************
   // control registers
   // ********************************************************
   always_ff @(posedge REF_CLK_I) begin
      if (RST_I) begin
         ctrl_reg         <= '0;
         clock_select_reg <= dwtc_pkg::CS_STOP;
         mask_reg         <= dwtc_pkg::RST_FLAGS;
      end else begin
         if (wr_to(dwtc_pkg::OFS_CONTROL_A)) begin
            ctrl_reg <= wr_byte[2:0];
         end
         if (wr_to(dwtc_pkg::OFS_CLOCK_SELECT)) begin
            clock_select_reg <= wr_byte[2:0];
         end
         if (wr_to(dwtc_pkg::OFS_MASK)) begin
            mask_reg <= wr_byte[3:0];
         end
      end
   end

   // prescaler reset: one-cycle pulse, or held while the hold bit is set
   always_ff @(posedge REF_CLK_I) begin
      if (RST_I) begin
         sync_hold_reg <= 1'b0;
         psr_reg       <= 1'b0;
      end else if (wr_to(dwtc_pkg::OFS_SYNC_CTRL)) begin
         sync_hold_reg <= wr_byte[dwtc_pkg::BIT_SYNC_HOLD];
         psr_reg       <= wr_byte[dwtc_pkg::BIT_PSR];
      end else begin
         psr_reg <= psr_reg & sync_hold_reg;
      end
   end

   // ********************************************************
   // counter unit
   // ********************************************************
   assign wide                = ctrl_reg.width_select;
   assign clear_on_match_mode = ctrl_reg.waveform_select
                                && !ctrl_reg.capture_enable_select;
   assign count_now = wide ? {count_high_reg, count_low_reg} : {8'h00, count_low_reg};
   assign max_value = wide ? dwtc_pkg::MAX_16BIT : dwtc_pkg::MAX_8BIT;
   always_comb begin
      if (clear_on_match_mode) begin
         top_value = wide ? {compare_b_reg, compare_a_reg}
                          : {8'h00, compare_a_reg};
      end else begin
         top_value = max_value;
      end
   end
   assign at_max = (count_now == max_value);
   assign at_top = clear_on_match_mode && (count_now == top_value);
   // a TOP below the count is missed until the count wraps at MAX
   assign count_next = (at_max || at_top) ? dwtc_pkg::BOTTOM : count_now + 16'h0001;
   assign count_write = wr_to(dwtc_pkg::OFS_COUNT_LOW) || wr_to(dwtc_pkg::OFS_COUNT_HIGH);

   always_ff @(posedge REF_CLK_I) begin
      if (RST_I) begin
         count_low_reg  <= dwtc_pkg::RST_BYTE;
         count_high_reg <= dwtc_pkg::RST_BYTE;
      end else if (count_write) begin
         // software wins over the count in the same cycle
         if (wr_to(dwtc_pkg::OFS_COUNT_LOW)) begin
            count_low_reg <= wr_byte;
         end
         if (wr_to(dwtc_pkg::OFS_COUNT_HIGH)) begin
            count_high_reg <= wr_byte;
         end
      end else if (timer_tick) begin
         count_low_reg <= count_next[7:0];
         if (wide) begin
            count_high_reg <= count_next[15:8];
         end
      end
   end

   // ********************************************************
   // compare and capture registers
   // ********************************************************
   // in capture mode compare A (and B when 16-bit) holds the captured count
   assign capture_take = CAPTURE_EVENT_I && ctrl_reg.capture_enable_select;
   always_ff @(posedge REF_CLK_I) begin
      if (RST_I) begin
         compare_a_reg <= dwtc_pkg::RST_BYTE;
         compare_b_reg <= dwtc_pkg::RST_BYTE;
      end else begin
         if (wr_to(dwtc_pkg::OFS_COMPARE_A)) begin
            compare_a_reg <= wr_byte;
         end else if (capture_take) begin
            compare_a_reg <= count_low_reg;
         end
         if (wr_to(dwtc_pkg::OFS_COMPARE_B)) begin
            compare_b_reg <= wr_byte;
         end else if (capture_take && wide) begin
            compare_b_reg <= count_high_reg;
         end
      end
   end

   // 8-bit: A and B compare separately; 16-bit: one joined compare
   assign match_a = timer_tick && !ctrl_reg.capture_enable_select
                    && (wide ? (count_now == {compare_b_reg, compare_a_reg})
                             : (count_low_reg == compare_a_reg));
   assign match_b = timer_tick && !wide && (count_low_reg == compare_b_reg);

   // ********************************************************
   // flags and interrupt line
   // ********************************************************
   always_ff @(posedge REF_CLK_I) begin
      if (RST_I) begin
         flag_reg <= dwtc_pkg::RST_FLAGS;
      end else begin
         // a new event in the clearing cycle still sets its flag
         flag_reg <= (flag_reg
                      & ~(wr_to(dwtc_pkg::OFS_FLAG) ? wr_byte[3:0] : 4'h0)
                      & ~INT_ACK_I)
                     | {capture_take, match_b, match_a,
                        timer_tick && at_max && !count_write};
      end
   end

   always_ff @(posedge REF_CLK_I) begin
      if (RST_I) begin
         TIMER_IRQ_O <= 1'b0;
      end else begin
         TIMER_IRQ_O <= |(flag_reg & mask_reg);
      end
   end

   // ********************************************************
   // assertions
   // ********************************************************
   psr_pulse_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
      psr_reg && !sync_hold_reg && !wr_to(dwtc_pkg::OFS_SYNC_CTRL) |=> !psr_reg)
      else $error("prescaler reset did not self-clear");

   hold_keep_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
      psr_reg && sync_hold_reg && !wr_to(dwtc_pkg::OFS_SYNC_CTRL) |=> psr_reg && !timer_tick)
      else $error("held prescaler reset was dropped");

   hold_release_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
      !sync_hold_reg && !wr_to(dwtc_pkg::OFS_SYNC_CTRL) |=> !psr_reg)
      else $error("prescaler reset stuck without hold");

   stop_idle_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
      clock_select_reg == dwtc_pkg::CS_STOP && !count_write |=> $stable(count_low_reg))
      else $error("stopped counter moved");

   write_wins_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
      wr_to(dwtc_pkg::OFS_COUNT_LOW) |=> count_low_reg == $past(wr_byte))
      else $error("count write lost to counting");

   count_up_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
      timer_tick && !count_write && !at_max && !at_top
      |=> count_low_reg == $past(count_low_reg) + 8'h01)
      else $error("counter did not increment");

   wrap_ovf_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
      timer_tick && !count_write && !wide && count_low_reg == 8'hFF
      |=> count_low_reg == 8'h00 && flag_reg[dwtc_pkg::FLAG_OVERFLOW])
      else $error("8-bit wrap or overflow flag wrong");

   wide_wrap_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
      timer_tick && !count_write && wide && count_now == 16'hFFFF
      |=> {count_high_reg, count_low_reg} == 16'h0000)
      else $error("16-bit counter did not wrap at MAX");

   match_clear_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
      timer_tick && !count_write && clear_on_match_mode && !wide
      && count_low_reg == compare_a_reg |=> count_low_reg == 8'h00)
      else $error("clear on match missed");

   irq_follow_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
      |(flag_reg & mask_reg) |=> TIMER_IRQ_O)
      else $error("masked flag did not raise interrupt");

   ovf_cov: cover property (@(posedge REF_CLK_I) disable iff (RST_I)
      timer_tick && at_max ##1 TIMER_IRQ_O);
   match_cov: cover property (@(posedge REF_CLK_I) disable iff (RST_I)
      timer_tick && at_top && clear_on_match_mode);
   hold_cov: cover property (@(posedge REF_CLK_I) disable iff (RST_I)
      psr_reg && sync_hold_reg ##1 !sync_hold_reg);
endmodule // dwtc_timer
`default_nettype wire

// ==== logic/dwtc_pkg.sv ====
`default_nettype none
package dwtc_pkg;
   // ********************************************************
   // register map (byte addresses, one aligned word each)
   // ********************************************************
   localparam logic [5:0] OFS_CONTROL_A    = 6'h00;
   localparam logic [5:0] OFS_CLOCK_SELECT = 6'h04;
   localparam logic [5:0] OFS_SYNC_CTRL    = 6'h08;
   localparam logic [5:0] OFS_COUNT_LOW    = 6'h0C;
   localparam logic [5:0] OFS_COUNT_HIGH   = 6'h10;
   localparam logic [5:0] OFS_COMPARE_A    = 6'h14;
   localparam logic [5:0] OFS_COMPARE_B    = 6'h18;
   localparam logic [5:0] OFS_FLAG         = 6'h1C;
   localparam logic [5:0] OFS_MASK         = 6'h20;
   // ********************************************************
   // field positions
   // ********************************************************
   localparam int BIT_WAVEFORM   = 0;
   localparam int BIT_WIDTH      = 1;
   localparam int BIT_CAPTURE_EN = 2;
   localparam int BIT_SYNC_HOLD  = 7;
   localparam int BIT_PSR        = 0;
   localparam int FLAG_OVERFLOW  = 0;
   localparam int FLAG_COMPARE_A = 1;
   localparam int FLAG_COMPARE_B = 2;
   localparam int FLAG_CAPTURE   = 3;
   // ********************************************************
   // reset values and fixed counts
   // ********************************************************
   localparam logic [7:0]  RST_BYTE   = 8'h00;
   localparam logic [3:0]  RST_FLAGS  = 4'h0;
   localparam logic [15:0] MAX_8BIT   = 16'h00FF;
   localparam logic [15:0] MAX_16BIT  = 16'hFFFF;
   localparam logic [15:0] BOTTOM     = 16'h0000;
   localparam int          PRESC_BITS = 10;
   // log2 of the prescaler taps 8, 64, 256, 1024
   localparam int          TAP_LOG2 [4] = '{3, 6, 8, 10};
   // ********************************************************
   // clock select codes and bus response codes
   // ********************************************************
   localparam logic [2:0] CS_STOP     = 3'h0;
   localparam logic [2:0] CS_DIRECT   = 3'h1;
   localparam logic [2:0] CS_EXT_FALL = 3'h6;
   localparam logic [2:0] CS_EXT_RISE = 3'h7;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic capture_enable_select;
      logic width_select;
      logic waveform_select;
   } dwtc_ctrl_s;
endpackage
`default_nettype wire

// ==== logic/dwtc_tick_gen.sv ====
`timescale 1ns/1ps
`default_nettype none
module dwtc_tick_gen #(
   parameter int PRESCALER_BITS = dwtc_pkg::PRESC_BITS
) (
   input  wire logic       clk_i,                // io clock
   input  wire logic       rst_i,                // sync reset, high
   input  wire logic [2:0] clock_select_i,       // clock select field
   input  wire logic       prescaler_reset_i,    // shared prescaler reset
   input  wire logic       external_count_pin_i, // external count pin level
   output logic            timer_tick_o          // one-cycle timer tick
);
   logic [PRESCALER_BITS-1:0] presc_reg;
   logic [3:0]                tap;
   logic                      pin_meta_reg;
   logic                      pin_sync_reg;
   logic                      pin_prev_reg;

   // ********************************************************
   // free running prescaler
   // ********************************************************
   always_ff @(posedge clk_i) begin
      if (rst_i || prescaler_reset_i) begin
         presc_reg <= '0;
      end else begin
         presc_reg <= presc_reg + 1'b1;
      end
   end

   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_tap
         assign tap[g] = &presc_reg[dwtc_pkg::TAP_LOG2[g]-1:0];
      end
   endgenerate

   // ********************************************************
   // external pin: two-flop sync then edge detect
   // ********************************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin_meta_reg <= 1'b0;
         pin_sync_reg <= 1'b0;
         pin_prev_reg <= 1'b0;
      end else begin
         pin_meta_reg <= external_count_pin_i;
         pin_sync_reg <= pin_meta_reg;
         pin_prev_reg <= pin_sync_reg;
      end
   end

   always_comb begin
      timer_tick_o = 1'b0;
      case (clock_select_i)
         dwtc_pkg::CS_STOP:     timer_tick_o = 1'b0;
         dwtc_pkg::CS_DIRECT:   timer_tick_o = 1'b1;
         3'h2:                  timer_tick_o = tap[0];
         3'h3:                  timer_tick_o = tap[1];
         3'h4:                  timer_tick_o = tap[2];
         3'h5:                  timer_tick_o = tap[3];
         dwtc_pkg::CS_EXT_FALL: timer_tick_o = pin_prev_reg & ~pin_sync_reg;
         dwtc_pkg::CS_EXT_RISE: timer_tick_o = pin_sync_reg & ~pin_prev_reg;
         default:               timer_tick_o = 1'b0;
      endcase
      // a held prescaler reset halts every source
      if (prescaler_reset_i) begin
         timer_tick_o = 1'b0;
      end
   end
endmodule // dwtc_tick_gen
`default_nettype wire

// ==== test/dwtc_pin_drv.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****
// far-side count pin driver
// ****
module dwtc_pin_drv (
   input  wire logic clk_i, // io clock
   input  wire logic rst_i, // sync reset, high
   input  wire logic run_i, // toggle while high
   output logic      pin_o  // count pin level, low at rest
);
   logic [1:0] cnt_reg;
   // three clocks per half period keeps the pin below io clock / 2.5
   always_ff @(posedge clk_i) begin
      cnt_reg <= (rst_i || !run_i || cnt_reg == 2'h2) ? 2'h0 : cnt_reg + 2'h1;
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin_o <= 1'b0;
      end else if (run_i && cnt_reg == 2'h2) begin
         pin_o <= ~pin_o;
      end
   end
endmodule // dwtc_pin_drv
`default_nettype wire

// ==== test/dual_width_timer_counter_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module dual_width_timer_counter_test;
   typedef struct packed {logic [5:0] a; logic [7:0] d; logic [7:0] e; logic [1:0] r;} dwtc_row_s;
   logic        clk, rst, pin, run, awv, wv, arv, irq, awr, wrd, bv, arr, rv, cap;
   logic [3:0]  ack;
   logic [5:0]  awa, ara;
   logic [31:0] wd, rdat, v, w;
   logic [1:0]  bresp, rresp, r;
   int          fail_count, compares, cyc;
   dwtc_row_s   rows [8] = '{'{6'h00, 8'h07, 8'h07, 2'h0}, '{6'h00, 8'h00, 8'h00, 2'h0},
      '{6'h04, 8'hFD, 8'h05, 2'h0}, '{6'h04, 8'h00, 8'h00, 2'h0}, '{6'h14, 8'h5A, 8'h5A, 2'h0},
      '{6'h18, 8'hA5, 8'hA5, 2'h0}, '{6'h20, 8'h0F, 8'h0F, 2'h0}, '{6'h24, 8'h01, 8'h00, 2'h2}};
   // ****
   // design and far side
   // ****
   dwtc_pin_drv drv (.clk_i(clk), .rst_i(rst), .run_i(run), .pin_o(pin));
   dwtc_timer uut (.REF_CLK_I(clk), .RST_I(rst), .EXTERNAL_COUNT_PIN_I(pin),
      .CAPTURE_EVENT_I(cap), .INT_ACK_I(ack), .TIMER_IRQ_O(irq), .S_AXI_AWADDR(awa),
      .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF),
      .S_AXI_WVALID(wv), .S_AXI_WREADY(wrd), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv),
      .S_AXI_BREADY(1'b1), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
      .S_AXI_RDATA(rdat), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(1'b1));
   // ****
   // bus and check tasks
   // ****
   task chk(input logic [31:0] s, input logic [31:0] e);
      compares++;
      if (s !== e) begin
         fail_count++;
         $display("wrong value at %0t: saw %h, expected %h", $time, s, e);
      end
   endtask
   task wr(input logic [5:0] a, input logic [7:0] d);
      awa <= a;
      wd <= {24'h0, d};
      awv <= 1'b1;
      wv <= 1'b1;
      do begin
         @(posedge clk);
         if (awr) awv <= 1'b0;
         if (wrd) wv <= 1'b0;
      end while (!bv);
      r = bresp;
   endtask
   task rd(input logic [5:0] a);
      ara <= a;
      arv <= 1'b1;
      do begin
         @(posedge clk);
         if (arr) arv <= 1'b0;
      end while (!rv);
      v = rdat;
      r = rresp;
   endtask
   task report_and_stop;
      $display("mismatches %0d of %0d compares", fail_count, compares);
      if (fail_count == 0 && compares > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // a hung handshake ends the run here
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         report_and_stop;
      end
   end
   // ****
   // main sequence
   // ****
   initial begin
      {rst, run, awv, wv, arv, cap, awa, ara, wd, ack} = {6'h20, 6'h0, 6'h0, 32'h0, 4'h0};
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      for (int i = 0; i < 9; i++) begin
         rd(6'(4 * i));
         chk(v, 32'h0);
      end
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d);
         chk(32'(r), 32'(rows[i].r));
         rd(rows[i].a);
         chk(32'(r), 32'(rows[i].r));
         if (rows[i].r == 2'h0) chk(v, 32'(rows[i].e));
      end
      wr(6'h0C, 8'hFE);
      wr(6'h04, 8'h01);
      wr(6'h04, 8'h00);
      rd(6'h1C);
      chk(v & 32'h1, 32'h1);
      chk(32'(irq), 32'h1);
      rd(6'h0C);
      w = v;
      rd(6'h0C);
      chk(v, w);
      wr(6'h1C, 8'h00);
      rd(6'h1C);
      chk(v & 32'h1, 32'h1);
      wr(6'h1C, 8'h01);
      rd(6'h1C);
      chk(v & 32'h1, 32'h0);
      chk(32'(irq), 32'h0);
      wr(6'h0C, 8'h00);
      wr(6'h08, 8'h81);
      wr(6'h04, 8'h01);
      rd(6'h0C);
      chk(v, 32'h0);
      rd(6'h08);
      chk(v, 32'h81);
      wr(6'h08, 8'h00);
      rd(6'h08);
      chk(v, 32'h0);
      rd(6'h0C);
      chk(32'(v != 32'h0), 32'h1);
      wr(6'h08, 8'h01);
      rd(6'h08);
      chk(v, 32'h0);
      for (int k = 6; k < 8; k++) begin
         wr(6'h04, 8'h00);
         wr(6'h0C, 8'h00);
         wr(6'h04, 8'(k));
         run <= 1'b1;
         repeat (18) @(posedge clk);
         run <= 1'b0;
         repeat (4) @(posedge clk);
         rd(6'h0C);
         chk(v, 32'h3);
      end
      wr(6'h04, 8'h00);
      wr(6'h00, 8'h02);
      wr(6'h10, 8'hFF);
      wr(6'h0C, 8'hFE);
      wr(6'h04, 8'h01);
      wr(6'h04, 8'h00);
      rd(6'h10);
      chk(v, 32'h0);
      rd(6'h1C);
      chk(v & 32'h1, 32'h1);
      // servicing the overflow interrupt clears its flag
      ack <= 4'h1;
      @(posedge clk);
      ack <= 4'h0;
      rd(6'h1C);
      chk(v & 32'h1, 32'h0);
      // 8-bit clear-on-match, TOP 2, compare B at 1
      wr(6'h00, 8'h01);
      wr(6'h0C, 8'h00);
      wr(6'h14, 8'h02);
      wr(6'h18, 8'h01);
      wr(6'h1C, 8'h0F);
      wr(6'h04, 8'h01);
      repeat (10) @(posedge clk);
      wr(6'h04, 8'h00);
      rd(6'h0C);
      chk(32'(v < 32'h3), 32'h1);
      rd(6'h1C);
      chk(v, 32'h6);
      // divide by 8 tap over about 83 clocks
      wr(6'h00, 8'h00);
      wr(6'h0C, 8'h00);
      wr(6'h04, 8'h02);
      repeat (80) @(posedge clk);
      wr(6'h04, 8'h00);
      rd(6'h0C);
      chk(32'(v >= 32'hA && v <= 32'h10), 32'h1);
      // 8-bit capture copies the count into compare A
      wr(6'h00, 8'h04);
      wr(6'h0C, 8'h33);
      cap <= 1'b1;
      @(posedge clk);
      cap <= 1'b0;
      rd(6'h14);
      chk(v, 32'h33);
      rd(6'h1C);
      chk(v & 32'h8, 32'h8);
      // reset in mid-run clears flags, line and compare
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chk(32'(irq), 32'h0);
      rd(6'h1C);
      chk(v, 32'h0);
      rd(6'h14);
      chk(v, 32'h0);
      report_and_stop;
   end
endmodule // dual_width_timer_counter_test
`default_nettype wire
